// ===== src/spi_cfg_defs.svh
// constants for the serial configuration port and clock stabilizer control
// assumes inclusion by bare name from design files under src/
// Operation
// - frame starts on select low, clock rise
// - 16-bit instruction, then word-length counted bytes
// - ignore serial pins while select high
// - select high between bytes stalls, resumes; here only counted writes resume, a stream restarts at the instruction, a read byte after a stall is not reloaded
// - word length 11 selects streaming
// - select high mid-byte resets serial machine
// - select strapped high selects pin-strap functions
// - select tied low gives two-wire mode
// - two-wire streaming cannot be left
// - instruction decodes read/write and length
// - readback turns data pin to output
// - msb first default, lsb first selectable
// - pull-up keeps select high when undriven
// - stabilizer gives 50 percent duty clock
// - stabilizer can be disabled
// - eight sample clocks to relock
// - commit write 0x01 at 0xFF updates
// - 0x00, 0x04, 0x05, 0xFF act at once
// - input sampled on rising serial clock
`ifndef SPI_CFG_DEFS_SVH
`define SPI_CFG_DEFS_SVH
`define ADDR_PORT_CFG    13'h0000
`define ADDR_CHIP_ID     13'h0001
`define ADDR_INDEX_2     13'h0004
`define ADDR_INDEX_1     13'h0005
`define ADDR_MODES       13'h0008
`define ADDR_CLOCK       13'h0009
`define ADDR_MUX         13'h000C
`define ADDR_UPDATE      13'h00FF
`define RST_PORT_CFG     8'h18
`define RST_INDEX        8'h0F
`define RST_MODES        8'h00
`define RST_CLOCK        8'h01
`define RST_MUX          8'h00
`define CHIP_ID_VALUE    8'h5A
`define BIT_LSB_HI       6
`define BIT_RESET_HI     5
`define BIT_RESET_LO     2
`define BIT_LSB_LO       1
`define BIT_COMMIT       0
`define BIT_STABILIZER   0
`define INSTR_BITS       16
`define RELOCK_CYCLES    8
`define WL_STREAM        2'h3
`endif

// ===== src/spi_cfg_pkg.sv
// types shared by the serial configuration port modules
// assumes nothing beyond the constants header
package spi_cfg_pkg;
  typedef enum logic [1:0]
  {
    ST_INSTR = 2'h0,
    ST_DATA  = 2'h1
  } link_state_t;
  typedef logic [12:0] reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
endpackage

// ===== src/reg_xfer_if.sv
// register access path between the serial link and the register file
// writes are toggle events crossing from serial clock to mclk; reads go through a combinational mux
`timescale 1ns/1ps
interface reg_xfer_if;
  import spi_cfg_pkg::*;
  logic      wr_toggle;
  reg_addr_t wr_addr;
  reg_byte_t wr_data;
  reg_addr_t rd_addr;
  reg_byte_t rd_data;
  logic      lsb_first;
  modport link
  (
    output wr_toggle,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data,
    input  lsb_first
  );
  modport regs
  (
    input  wr_toggle,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data,
    output lsb_first
  );
endinterface

// ===== src/spi_link.sv
// serial shift logic on the serial clock; reset clears the frame, select high clears the bit count and restarts only a cut byte or a stream
// assumes the clock only toggles inside frames; select high idles the link
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module spi_link
  import spi_cfg_pkg::*;
(
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  reg_xfer_if.link  xfer
);
  link_state_t state_reg, state_next;
  link_state_t state_cur;
  logic [4:0]  cnt_reg, cnt_next;
  logic [15:0] sh_reg, sh_next;
  logic        rw_reg, rw_next;
  logic [1:0]  wl_reg, wl_next;
  logic [1:0]  left_reg, left_next;
  reg_addr_t   addr_reg, addr_next;
  reg_addr_t   waddr_reg, waddr_next;
  reg_byte_t   wdata_reg, wdata_next;
  logic        wtog_reg, wtog_next;
  logic        frag_reg, frag_next;
  logic        fresh_reg;
  logic        link_clr;
  reg_byte_t   rsh_reg;
  logic        oe_reg;
  logic        lsb_f;
  logic        word_done;

  function automatic reg_byte_t rev_byte(input reg_byte_t b);
    reg_byte_t r;
    for (int i = 0; i < 8; i++)
      r[i] = b[7 - i];
    return r;
  endfunction

  assign lsb_f     = xfer.lsb_first;
  assign link_clr  = cs_n | ~rst_n;
  // a frame cut mid-byte, or a stream ended by select, restarts at the instruction
  assign state_cur = (fresh_reg && frag_reg) ? ST_INSTR : state_reg;
  assign word_done = (state_cur == ST_INSTR) ? (cnt_reg == 5'd15) : (cnt_reg == 5'd7);

  always_comb
  begin
    state_next = state_cur;
    cnt_next   = cnt_reg + 5'd1;
    sh_next    = lsb_f ? {sdio_in, sh_reg[15:1]} : {sh_reg[14:0], sdio_in};
    rw_next    = rw_reg;
    wl_next    = wl_reg;
    left_next  = left_reg;
    addr_next  = addr_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wtog_next  = wtog_reg;
    if (word_done)
    begin
      cnt_next = 5'd0;
      if (state_cur == ST_INSTR)
      begin
        // lsb-first reverses all 16 bits, so the word lands in place
        rw_next    = sh_next[15];
        wl_next    = sh_next[14:13];
        addr_next  = sh_next[12:0];
        left_next  = wl_next;
        state_next = ST_DATA;
      end
      else
      begin
        if (!rw_reg)
        begin
          // write address held apart so the address step cannot race the crossing
          waddr_next = addr_reg;
          wdata_next = lsb_f ? sh_next[15:8] : sh_next[7:0];
          wtog_next  = ~wtog_reg;
        end
        addr_next = lsb_f ? addr_reg + 13'd1 : addr_reg - 13'd1;
        if (wl_reg != `WL_STREAM) // streaming runs until select rises
        begin
          left_next = left_reg - 2'd1;
          if (left_reg == 2'd0)
            state_next = ST_INSTR;
        end
      end
    end
    frag_next = (cnt_next != 5'd0) || (state_next == ST_DATA && wl_next == `WL_STREAM);
    if (cs_n) // clock edges while deselected change nothing
    begin
      state_next = state_reg;
      rw_next    = rw_reg;
      wl_next    = wl_reg;
      left_next  = left_reg;
      addr_next  = addr_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wtog_next  = wtog_reg;
      frag_next  = frag_reg;
    end
  end

  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_INSTR; // power-up leaves the link waiting for an instruction
      rw_reg    <= 1'b0;
      wl_reg    <= 2'h0;
      left_reg  <= 2'h0;
      addr_reg  <= 13'h0000;
      waddr_reg <= 13'h0000;
      wdata_reg <= 8'h00;
      wtog_reg  <= 1'b0;
      frag_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rw_reg    <= rw_next;
      wl_reg    <= wl_next;
      left_reg  <= left_next;
      addr_reg  <= addr_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wtog_reg  <= wtog_next;
      frag_reg  <= frag_next;
    end
  end

  // select high clears the bit count; finished bytes keep their place
  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      cnt_reg   <= 5'd0;
      sh_reg    <= 16'h0000;
      fresh_reg <= 1'b1;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      fresh_reg <= 1'b0;
    end
  end

  // drive on falling edges during read data bytes; bit 7 is the pin
  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      oe_reg  <= 1'b0;
      rsh_reg <= 8'h00;
    end
    else if (state_reg == ST_DATA && rw_reg)
    begin
      oe_reg <= 1'b1;
      if (cnt_reg == 5'd0)
        rsh_reg <= lsb_f ? rev_byte(xfer.rd_data) : xfer.rd_data;
      else
        rsh_reg <= {rsh_reg[6:0], 1'b0};
    end
    else
      oe_reg <= 1'b0;
  end

  assign sdio_out       = rsh_reg[7];
  assign sdio_oe        = oe_reg;
  assign xfer.wr_toggle = wtog_reg;
  assign xfer.wr_addr   = waddr_reg;
  assign xfer.wr_data   = wdata_reg;
  assign xfer.rd_addr   = addr_reg;
endmodule

// ===== src/cfg_regs.sv
// register file on mclk; modes, clock and mux have shadow and active copies
// write events arrive as a toggle; address/data are stable when it flips
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module cfg_regs
  import spi_cfg_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  reg_xfer_if.regs  xfer,
  output reg_byte_t port_cfg,
  output reg_byte_t index_2,
  output reg_byte_t index_1,
  output reg_byte_t modes_act,
  output reg_byte_t clock_act,
  output reg_byte_t mux_act,
  output logic      soft_reset
);
  logic [2:0] tog_reg;
  reg_byte_t  port_reg, idx2_reg, idx1_reg;
  reg_byte_t  modes_sh, clock_sh, mux_sh;
  reg_byte_t  modes_reg, clock_reg, mux_reg;
  logic       wr;
  logic       commit;

  assign wr     = tog_reg[2] ^ tog_reg[1];
  assign commit = wr && xfer.wr_addr == `ADDR_UPDATE && xfer.wr_data[`BIT_COMMIT];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_reg   <= 3'h0;
      port_reg  <= `RST_PORT_CFG;
      idx2_reg  <= `RST_INDEX;
      idx1_reg  <= `RST_INDEX;
      modes_sh  <= `RST_MODES;
      clock_sh  <= `RST_CLOCK;
      mux_sh    <= `RST_MUX;
      modes_reg <= `RST_MODES;
      clock_reg <= `RST_CLOCK;
      mux_reg   <= `RST_MUX;
    end
    else
    begin
      tog_reg <= {tog_reg[1:0], xfer.wr_toggle};
      if (port_reg[`BIT_RESET_HI] || port_reg[`BIT_RESET_LO])
      begin
        port_reg  <= `RST_PORT_CFG;
        idx2_reg  <= `RST_INDEX;
        idx1_reg  <= `RST_INDEX;
        modes_sh  <= `RST_MODES;
        clock_sh  <= `RST_CLOCK;
        mux_sh    <= `RST_MUX;
        modes_reg <= `RST_MODES;
        clock_reg <= `RST_CLOCK;
        mux_reg   <= `RST_MUX;
      end
      else if (wr)
      begin
        if (xfer.wr_addr == `ADDR_PORT_CFG)
          port_reg <= xfer.wr_data;
        else if (xfer.wr_addr == `ADDR_INDEX_2)
          idx2_reg <= xfer.wr_data;
        else if (xfer.wr_addr == `ADDR_INDEX_1)
          idx1_reg <= xfer.wr_data;
        else if (xfer.wr_addr == `ADDR_MODES)
          modes_sh <= xfer.wr_data;
        else if (xfer.wr_addr == `ADDR_CLOCK)
          clock_sh <= xfer.wr_data;
        else if (xfer.wr_addr == `ADDR_MUX)
          mux_sh <= xfer.wr_data;
        if (commit)
        begin
          modes_reg <= modes_sh;
          clock_reg <= clock_sh;
          mux_reg   <= mux_sh;
        end
      end
    end
  end

  // readback mux is combinational across domains; the master reads stable data
  always_comb
  begin
    if (xfer.rd_addr == `ADDR_PORT_CFG)
      xfer.rd_data = port_reg;
    else if (xfer.rd_addr == `ADDR_CHIP_ID)
      xfer.rd_data = `CHIP_ID_VALUE;
    else if (xfer.rd_addr == `ADDR_INDEX_2)
      xfer.rd_data = idx2_reg;
    else if (xfer.rd_addr == `ADDR_INDEX_1)
      xfer.rd_data = idx1_reg;
    else if (xfer.rd_addr == `ADDR_MODES)
      xfer.rd_data = modes_sh;
    else if (xfer.rd_addr == `ADDR_CLOCK)
      xfer.rd_data = clock_sh;
    else if (xfer.rd_addr == `ADDR_MUX)
      xfer.rd_data = mux_sh;
    else
      xfer.rd_data = 8'h00;
  end
  assign xfer.lsb_first = port_reg[`BIT_LSB_HI] | port_reg[`BIT_LSB_LO];
  assign port_cfg   = port_reg;
  assign index_2    = idx2_reg;
  assign index_1    = idx1_reg;
  assign modes_act  = modes_reg;
  assign clock_act  = clock_reg;
  assign mux_act    = mux_reg;
  assign soft_reset = port_reg[`BIT_RESET_HI] | port_reg[`BIT_RESET_LO];
endmodule

// ===== src/adc_serial_config_port.sv
// top: serial configuration port, register file, strap and stabilizer control
// assumes sclk is the serial link clock; sample clock is seen as a pulse on mclk
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module adc_serial_config_port
  import spi_cfg_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic cs_n_pin,
  input  wire logic cs_n_driven,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  input  wire logic sample_clk,
  output logic      strap_mode,
  output logic      two_wire_mode,
  output logic      stabilizer_on,
  output logic      clk_locked,
  output reg_byte_t channel_index,
  output reg_byte_t power_mode,
  output reg_byte_t mux_select
);
  reg_xfer_if xfer ();
  logic      cs_n;
  reg_byte_t port_cfg, idx2, idx1, modes, clk_r, mux;
  logic      soft_reset;
  logic [1:0] cs_sync_reg;
  logic [2:0] smp_sync_reg;
  logic       strap_reg, strap_next;
  logic       twow_reg, twow_next;
  logic       caught_reg, caught_next;
  logic       dcs_reg, dcs_next;
  logic [3:0] lock_cnt_reg, lock_cnt_next;
  logic       lock_reg, lock_next;
  reg_byte_t  idx_reg, pwr_reg, mux_reg;

  assign cs_n = cs_n_driven ? cs_n_pin : 1'b1; // undriven select reads high

  spi_link u_link
  (
    .rst_n    (rst_n),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdio_in  (sdio_in),
    .sdio_out (sdio_out),
    .sdio_oe  (sdio_oe),
    .xfer     (xfer.link)
  );

  cfg_regs u_regs
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .xfer       (xfer.regs),
    .port_cfg   (port_cfg),
    .index_2    (idx2),
    .index_1    (idx1),
    .modes_act  (modes),
    .clock_act  (clk_r),
    .mux_act    (mux),
    .soft_reset (soft_reset)
  );

  always_comb
  begin
    caught_next   = 1'b1;
    strap_next    = strap_reg;
    twow_next     = twow_reg;
    if (!caught_reg)
    begin
      strap_next = cs_sync_reg[1];
      twow_next  = ~cs_sync_reg[1];
    end
    dcs_next      = clk_r[`BIT_STABILIZER];
    lock_cnt_next = lock_cnt_reg;
    lock_next     = lock_reg;
    if (dcs_next != dcs_reg)
    begin
      lock_cnt_next = 4'd0;
      lock_next     = 1'b0;
    end
    else if (!lock_reg && smp_sync_reg[2] == 1'b0 && smp_sync_reg[1] == 1'b1)
    begin
      lock_cnt_next = lock_cnt_reg + 4'd1;
      if (lock_cnt_reg == 4'(`RELOCK_CYCLES - 1))
        lock_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_sync_reg <= 3'b000;
      caught_reg   <= 1'b0;
      strap_reg    <= 1'b0;
      twow_reg     <= 1'b0;
      dcs_reg      <= 1'b1;
      lock_cnt_reg <= 4'd0;
      lock_reg     <= 1'b0;
      idx_reg      <= 8'h00;
      pwr_reg      <= 8'h00;
      mux_reg      <= 8'h00;
    end
    else
    begin
      smp_sync_reg <= {smp_sync_reg[1:0], sample_clk};
      caught_reg   <= caught_next;
      strap_reg    <= strap_next;
      twow_reg     <= twow_next;
      dcs_reg      <= dcs_next;
      lock_cnt_reg <= lock_cnt_next;
      lock_reg     <= lock_next;
      idx_reg      <= {idx2[1:0], idx1[3:0], 2'b00};
      pwr_reg      <= modes;
      mux_reg      <= mux;
    end
  end

  // select synchroniser runs through reset so the strap sees the settled pin at release
  always_ff @(posedge mclk)
  begin
    cs_sync_reg <= {cs_sync_reg[0], cs_n};
  end

  assign strap_mode    = strap_reg;
  assign two_wire_mode = twow_reg;
  assign stabilizer_on = dcs_reg;
  assign clk_locked    = lock_reg;
  assign channel_index = idx_reg;
  assign power_mode    = pwr_reg;
  assign mux_select    = mux_reg;
endmodule

// ===== dv/adc_serial_config_port_asserts.sv
// checker for the serial configuration port, bound to its top module
// sees only top-level ports; an undriven select counts as high
`timescale 1ns/1ps
module adc_serial_config_port_asserts
  import spi_cfg_pkg::*;
(
  input wire logic      mclk,
  input wire logic      rst_n,
  input wire logic      sclk,
  input wire logic      cs_n_pin,
  input wire logic      cs_n_driven,
  input wire logic      sdio_oe,
  input wire logic      sample_clk,
  input wire logic      strap_mode,
  input wire logic      two_wire_mode,
  input wire logic      stabilizer_on,
  input wire logic      clk_locked,
  input wire reg_byte_t power_mode,
  input wire reg_byte_t mux_select
);
  logic       cs_hi;
  logic       samp_q;
  logic       stab_q;
  logic [3:0] rises;
  logic [4:0] bits;
  assign cs_hi = !cs_n_driven || cs_n_pin;
  // sample rises since the last stabilizer change; one of slack for the synchroniser
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_q <= 1'b0;
      stab_q <= 1'b1;
      rises  <= 4'h0;
    end
    else
    begin
      samp_q <= sample_clk;
      stab_q <= stabilizer_on;
      if (clk_locked || stab_q != stabilizer_on)
        rises <= 4'h0;
      else if (sample_clk && !samp_q && rises != 4'hF)
        rises <= rises + 4'h1;
    end
  end
  always_ff @(posedge sclk or posedge cs_hi)
  begin
    if (cs_hi)
      bits <= 5'h0;
    else if (bits != 5'h1F)
      bits <= bits + 5'h1;
  end
  sequence s_deselected;
    cs_hi [*8];
  endsequence
  AST_RESET_STATE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> stabilizer_on && !clk_locked && power_mode == 8'h00 && mux_select == 8'h00)
    else $error("state after reset wrong");
  AST_MODE_EXCL: assert property (@(posedge mclk) disable iff (!rst_n)
    !(strap_mode && two_wire_mode)) else $error("strap and two-wire both set");
  AST_LOCK_DROPS: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(stabilizer_on) |-> ##[0:2] !clk_locked) else $error("lock kept after change");
  AST_LOCK_AFTER_EIGHT: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(clk_locked) |-> rises >= 4'h7 && rises <= 4'h9) else $error("lock count wrong");
  AST_QUIET_DESELECTED: assert property (@(posedge mclk) disable iff (!rst_n)
    s_deselected |=> $stable(power_mode) && $stable(mux_select) && $stable(stabilizer_on))
    else $error("register changed while deselected");
  AST_OE_OFF_DESELECTED: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_hi [*2] |-> !sdio_oe) else $error("data pin driven while deselected");
  AST_OE_AFTER_INSTR: assert property (@(posedge sclk) disable iff (cs_hi)
    $rose(sdio_oe) |-> bits == 5'h10) else $error("turnaround not after instruction");
  AST_READ_BYTE_WHOLE: assert property (@(posedge sclk) disable iff (cs_hi)
    $rose(sdio_oe) |-> sdio_oe [*8]) else $error("read byte cut short");
endmodule
bind adc_serial_config_port adc_serial_config_port_asserts adc_serial_config_port_asserts_inst
(
  .mclk, .rst_n, .sclk, .cs_n_pin, .cs_n_driven, .sdio_oe, .sample_clk, .strap_mode,
  .two_wire_mode, .stabilizer_on, .clk_locked, .power_mode, .mux_select
);

// ===== dv/spi_master_model.sv
// behavioural serial master driving configuration frames
// assumes the bench resolves the shared data wire and feeds it back
`timescale 1ns/1ps
module spi_master_model
(
  output logic      sclk,
  output logic      cs_n,
  output logic      cs_drv,
  output logic      sdo,
  output logic      sdo_oe,
  input  wire logic sdio_wire
);
  bit lsb = 1'b0;
  initial
  begin
    sclk   = 1'b0;
    cs_n   = 1'b1;
    cs_drv = 1'b1;
    sdo    = 1'b0;
    sdo_oe = 1'b0;
  end
  // data byte k sits at wd/rd[8k+:8]; select rises after abort_at bits
  // callers keep to one to three bytes, or a stream that select ends
  task automatic xfer(input logic rw, input logic [1:0] wl, input logic [12:0] addr,
                      input int n, input logic [23:0] wd, input bit stall, input int abort_at,
                      output logic [23:0] rd);
    logic [15:0] ins;
    int          k;
    int          b;
    ins = {rw, wl, addr};
    rd = 24'h0;
    #7 cs_n = 1'b0;
    for (int j = 0; j < 16 + 8 * n && j != abort_at; j++)
    begin
      k = (j - 16) / 8;
      b = lsb ? j % 8 : 7 - j % 8;
      if (stall && j > 16 && j % 8 == 0)
      begin
        cs_n = 1'b1;
        #96 cs_n = 1'b0;
      end
      sdo_oe = !(rw && j >= 16);
      sdo = j < 16 ? ins[lsb ? j : 15 - j] : wd[8 * k + b];
      #16 sclk = 1'b1;
      if (j >= 16)
        rd[8 * k + b] = sdio_wire;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    sdo_oe = 1'b0;
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the serial configuration port top module
// frames come from the master model; sample clock is derived from mclk
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module testbench;
  import spi_cfg_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sample_clk = 1'b0;
  logic [2:0]  sdiv = 3'h0;
  logic        sclk, cs_n, cs_drv, sdo, sdo_oe, sdio_out, sdio_oe, sdio_wire;
  logic        strap_mode, two_wire_mode, stabilizer_on, clk_locked;
  reg_byte_t   channel_index, power_mode, mux_select;
  logic [23:0] rd;
  int          miscompares = 0;
  int          checked = 0;
  // the data pin has a pull-down, so a released line reads low
  assign sdio_wire = sdio_oe ? sdio_out : (sdo_oe ? sdo : 1'b0);
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    sdiv <= sdiv + 3'h1;
    sample_clk <= sdiv[2];
  end
  spi_master_model spi_master_model_inst
  (
    .sclk, .cs_n, .cs_drv, .sdo, .sdo_oe, .sdio_wire
  );
  adc_serial_config_port adc_serial_config_port_inst
  (
    .mclk, .rst_n, .sclk, .cs_n_pin(cs_n), .cs_n_driven(cs_drv), .sdio_in(sdio_wire),
    .sdio_out, .sdio_oe, .sample_clk, .strap_mode, .two_wire_mode, .stabilizer_on,
    .clk_locked, .channel_index, .power_mode, .mux_select
  );
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic sel, input logic drv);
    @(posedge mclk);
    rst_n <= 1'b0;
    spi_master_model_inst.cs_n <= sel;
    spi_master_model_inst.cs_drv <= drv;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    spi_master_model_inst.cs_n <= 1'b1;
    spi_master_model_inst.cs_drv <= 1'b1;
  endtask
  task automatic wait_lock();
    for (int i = 0; i < 200 && clk_locked !== 1'b1; i++)
      @(posedge mclk);
    chk("clk_locked", 8'h01, {7'h0, clk_locked});
    if (clk_locked !== 1'b1)
      report_and_stop();
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi_master_model_inst.xfer(1'b0, 2'h0, a, 1, {16'h0, d}, 1'b0, -1, rd);
    repeat (8) @(posedge mclk);
  endtask
  initial
  begin
    do_reset(1'b0, 1'b1);
    chk("two_wire_mode", 8'h01, {7'h0, two_wire_mode});
    chk("strap_mode", 8'h00, {7'h0, strap_mode});
    do_reset(1'b0, 1'b0);
    chk("strap_mode", 8'h01, {7'h0, strap_mode});
    chk("stabilizer_on", 8'h01, {7'h0, stabilizer_on});
    wait_lock();
    $display("end reset test");
    spi_master_model_inst.xfer(1'b1, 2'h0, `ADDR_CHIP_ID, 1, 24'h0, 1'b0, -1, rd);
    chk("chip id", `CHIP_ID_VALUE, rd[7:0]);
    spi_master_model_inst.xfer(1'b1, `WL_STREAM, `ADDR_CHIP_ID, 2, 24'h0, 1'b0, -1, rd);
    chk("stream 0", `CHIP_ID_VALUE, rd[7:0]);
    chk("stream 1", `RST_PORT_CFG, rd[15:8]);
    $display("end readback test");
    wr(`ADDR_CLOCK, 8'h00);
    chk("stabilizer_on", 8'h01, {7'h0, stabilizer_on});
    wr(`ADDR_UPDATE, 8'h01);
    chk("stabilizer_on", 8'h00, {7'h0, stabilizer_on});
    chk("clk_locked", 8'h00, {7'h0, clk_locked});
    wait_lock();
    $display("end stabilizer test");
    spi_master_model_inst.xfer(1'b0, 2'h0, `ADDR_MUX, 1, 24'h77, 1'b0, 20, rd);
    spi_master_model_inst.xfer(1'b0, 2'h1, `ADDR_CLOCK, 2, 24'h0101, 1'b1, -1, rd);
    wr(`ADDR_MUX, 8'h05);
    chk("mux uncommitted", 8'h00, mux_select);
    wr(`ADDR_UPDATE, 8'h01);
    chk("mux_select", 8'h05, mux_select);
    chk("power_mode", 8'h01, power_mode);
    chk("stabilizer_on", 8'h01, {7'h0, stabilizer_on});
    wr(`ADDR_INDEX_2, 8'h02);
    wr(`ADDR_INDEX_1, 8'h05);
    chk("channel_index", 8'h94, channel_index);
    $display("end write test");
    wr(`ADDR_PORT_CFG, 8'h5A);
    spi_master_model_inst.lsb = 1'b1;
    spi_master_model_inst.xfer(1'b1, 2'h0, `ADDR_INDEX_1, 1, 24'h0, 1'b0, -1, rd);
    chk("lsb read", 8'h05, rd[7:0]);
    wr(`ADDR_INDEX_2, 8'h01);
    chk("lsb write", 8'h54, channel_index);
    $display("end bit order test");
    report_and_stop();
  end
endmodule
